// file: dv/ccd_readout_pattern_sequencer_tb.sv
// self-checking bench: frame starts per mode, judged through the sensor model and direct pin checks
`timescale 1ns/100ps
module ccd_readout_pattern_sequencer_tb;
  import ccd_seq_pkg::*;
  logic          clk, reset, start, cd_off, clear, busy, frame_done, pd_seen, pin_err;
  logic          bad_off, bad_map, bad_sw, bad_d;
  readout_mode_t mode;
  logic [23:0]   t_pd, t_ped, t_vx, t_hs;
  logic [15:0]   lines, pixels, rows, pix_cnt, pix_last;
  vert_pins_t    vert;
  horiz_pins_t   hor_a, hor_b, hor_c, hor_d;
  int            fail_count, checks, cycles;

  ccd_readout_pattern_sequencer #(.CW(24)) dut_u (.clk(clk), .reset(reset), .start(start),
    .mode(mode), .cd_off(cd_off), .t_pd(t_pd), .t_ped(t_ped), .t_vx(t_vx), .t_hs(t_hs),
    .lines(lines), .pixels(pixels), .vert(vert), .hor_a(hor_a), .hor_b(hor_b),
    .hor_c(hor_c), .hor_d(hor_d), .busy(busy), .frame_done(frame_done));
  ccd_sensor_model sensor_u (.clk(clk), .vert(vert), .hor_a(hor_a), .clear(clear), .rows(rows),
    .pix_cnt(pix_cnt), .pix_last(pix_last), .pd_seen(pd_seen), .pin_err(pin_err));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic do_reset();
    reset = 1'b1;
    tick(8);
    reset = 1'b0;
    clear = 1'b1;
    tick(1);
    clear = 1'b0;
  endtask : do_reset
  task automatic launch(input readout_mode_t m, input logic off, input logic [15:0] px);
    {bad_off, bad_map, bad_sw, bad_d} = 4'h0;
    mode   = m;
    cd_off = off;
    pixels = px;
    start  = 1'b1;
    tick(1);
    start  = 1'b0;
  endtask : launch
  // pin relations are sampled only once lines run, as outputs lag state
  task automatic watch(input logic [15:0] n);
    for (int i = 0; i < 30000 && rows < n; i++) begin
      tick(1);
      if (rows >= 16'h1) begin
        if (hor_c !== 6'h3f || hor_d !== 6'h3f) bad_off = 1'b1;
        if (vert.top !== {vert.bot[1], vert.bot[2], vert.bot[3], vert.bot[0]}) bad_map = 1'b1;
        if (hor_b.h1b !== hor_b.h2s || hor_b.h2b !== hor_b.h1s) bad_sw = 1'b1;
        if (hor_a.h1s !== hor_a.h1b) bad_sw = 1'b1;
        if (hor_d.h1b !== hor_a.h2s || hor_d.h2b !== hor_a.h1s || hor_d.h1s !== hor_a.h1s)
          bad_d = 1'b1;
        if (hor_b.rst !== 1'b1 || hor_d.rst !== 1'b1 || hor_c !== hor_a) bad_d = 1'b1;
      end
    end
  endtask : watch

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_quad();
    cmp(busy, 1'b0, "idle after reset");
    launch(MODE_QUAD, 1'b0, 16'h0);
    cmp(busy, 1'b1, "busy after start");
    mode  = MODE_SINGLE;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    watch(16'h3);
    cmp(pd_seen, 1'b1, "photodiode transfer");
    cmp(pix_last, 16'd1013, "quad pixels per line");
    cmp(pin_err, 1'b0, "last phase two");
    cmp({12'h0, vert.top}, {12'h0, vert.bot}, "quad top phases");
    reset = 1'b1;
    tick(1);
    cmp({6'h0, vert}, 16'h0, "vertical pins in reset");
    do_reset();
    $display("test quad done");
  endtask : t_quad
  task automatic t_dual();
    launch(MODE_DUAL_AB, 1'b1, 16'h0900);
    watch(16'h3);
    cmp(bad_off, 1'b0, "unused c/d at off");
    cmp(bad_map, 1'b0, "top phase mapping");
    cmp(pix_last, 16'h0900, "programmed pixels");
    cmp(pin_err, 1'b0, "last phase two");
    do_reset();
    $display("test dual done");
  endtask : t_dual
  task automatic t_single();
    launch(MODE_SINGLE, 1'b0, 16'h0);
    watch(16'h3);
    cmp(bad_sw, 1'b0, "b register swap");
    cmp(bad_map, 1'b0, "top phase mapping");
    cmp(pix_last, 16'd2026, "single pixels per line");
    do_reset();
    $display("test single done");
  endtask : t_single
  task automatic t_dual_ac();
    launch(MODE_DUAL_AC, 1'b1, 16'h0);
    watch(16'h3);
    cmp(bad_d, 1'b0, "d register cross, b/d resets off");
    cmp({12'h0, vert.top}, {12'h0, vert.bot}, "dual a/c top phases");
    cmp(pix_last, 16'd1013, "dual a/c pixels per line");
    do_reset();
    $display("test dual a/c done");
  endtask : t_dual_ac

  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // frames stop early on reset, so the run stays near 55k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      $display("Error %0t: run timed out", $time);
      summarize();
    end
  end
  initial begin
    {reset, start, cd_off, clear} = 4'h0;
    mode = MODE_QUAD;
    {t_pd, t_ped, t_vx, t_hs} = 96'h0;
    {lines, pixels} = 32'h0;
    do_reset();
    t_quad();
    t_dual();
    t_single();
    t_dual_ac();
    summarize();
  end
endmodule : ccd_readout_pattern_sequencer_tb

// file: dv/ccd_sensor_model.sv
// sensor side model: counts rows and pixel shifts seen on the clock pins
`timescale 1ns/100ps
module ccd_sensor_model (
  input  wire logic                     clk,
  input  wire ccd_seq_pkg::vert_pins_t  vert,
  input  wire ccd_seq_pkg::horiz_pins_t hor_a,
  input  wire logic                     clear,
  output logic [15:0]                   rows,
  output logic [15:0]                   pix_cnt,
  output logic [15:0]                   pix_last,
  output logic                          pd_seen,
  output logic                          pin_err
);
  import ccd_seq_pkg::*;
  logic v1_q, horiz_last_phase_two_q, p1h_q;
  // pins only move on clock edges, so sampling them there sees every edge;
  // clear zeroes the counts and flags so edges around reset are not counted
  always @(posedge clk) begin
    v1_q   <= vert.bot[0];
    horiz_last_phase_two_q <= hor_a.horiz_last_phase_two;
    p1h_q  <= vert.bot_p1_high;
    if (clear) begin
      rows     <= 16'h0;
      pix_cnt  <= 16'h0;
      pix_last <= 16'h0;
      pd_seen  <= 1'b0;
      pin_err  <= 1'b0;
    end else begin
      if (!p1h_q && vert.bot_p1_high) pd_seen <= 1'b1;
      // one row enters the horizontal register per phase-one fall
      // the dummy row shares the first fall with the first dark row
      if (v1_q && !vert.bot[0]) begin
        rows     <= rows + 16'h1;
        pix_last <= pix_cnt;
        pix_cnt  <= 16'h0;
      end else if (horiz_last_phase_two_q && !hor_a.horiz_last_phase_two) begin
        pix_cnt  <= pix_cnt + 16'h1; // each pixel leaves on the last phase-two fall
      end
      // last phase two must track storage phase two
      if (hor_a.horiz_last_phase_two !== hor_a.h2s) pin_err <= 1'b1;
    end
  end
endmodule : ccd_sensor_model

// file: hdl/ccd_readout_pattern_sequencer.sv
// timing generator driving the vertical and horizontal clocks of an interline ccd
`timescale 1ns/100ps
// Functional notes
// - every clocked pin gets one of seven patterns chosen by readout mode
// - top phases copy bottom in quad and dual a/c, else bottom 1,4,3,2; bottom fixed
// - h1 pins pattern five, h2 pins pattern six, resets seven, with mode swaps
// - unused c/d registers either keep clocking or sit at the off level
// - slower c/d clocking must be an integer multiple of a/b frequency
// - last phase-two clock copies its output's phase-two storage pattern
// - at least 572 or 1144 lines per frame depending on mode
// - vertical rising edges coincide with or slightly lead falling edges
// - keep that alignment where phase one drops high to mid as four rises
// - at least 1013 or 2026 pixel counts per row depending on mode
module ccd_readout_pattern_sequencer #(
  parameter int CW = 24
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      start,
  input  wire ccd_seq_pkg::readout_mode_t mode,
  input  wire logic                      cd_off,
  input  wire logic [CW-1:0]             t_pd,
  input  wire logic [CW-1:0]             t_ped,
  input  wire logic [CW-1:0]             t_vx,
  input  wire logic [CW-1:0]             t_hs,
  input  wire logic [15:0]               lines,
  input  wire logic [15:0]               pixels,
  output ccd_seq_pkg::vert_pins_t        vert,
  output ccd_seq_pkg::horiz_pins_t       hor_a,
  output ccd_seq_pkg::horiz_pins_t       hor_b,
  output ccd_seq_pkg::horiz_pins_t       hor_c,
  output ccd_seq_pkg::horiz_pins_t       hor_d,
  output logic                           busy,
  output logic                           frame_done
);
  import ccd_seq_pkg::*;

  if (CW < 12) begin : g_cw_check
    $error("counter width too small for minimum intervals");
  end

  // ---------------------------------------------------------------
  // frame sequencing
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PD_LEAD, ST_PD_HIGH, ST_PD_TRAIL, ST_VXFER, ST_HDELAY, ST_PIXEL
  } seq_state_t;

  seq_state_t       state_r, state_nxt;
  logic [CW-1:0]    cnt_r;
  logic [15:0]      line_r;
  logic [15:0]      pix_r;
  logic [2:0]       vstep_r;
  logic             hph_r;
  readout_mode_t    mode_r;
  logic             cdoff_r;
  logic             done_r;
  logic [7:0]       pd_len_r;

  // intervals clamp up to their minimum; a short setting is never honoured
  wire logic long_mode   = (mode_r == MODE_DUAL_AB) || (mode_r == MODE_SINGLE);
  wire logic [CW-1:0] w_pd  = CW'(cyc_max(int'(t_pd), CYC_PD));
  wire logic [CW-1:0] w_ped = CW'(cyc_max(int'(t_ped), cyc_max(CYC_3P, CYC_3D)));
  wire logic [CW-1:0] w_vx  = CW'(cyc_max(int'(t_vx), cyc_max(CYC_V, CYC_D)));
  wire logic [CW-1:0] w_hs  = CW'(cyc_max(int'(t_hs), CYC_HS));
  wire logic [15:0] min_lines = long_mode ? 16'(LINES_LONG) : 16'(LINES_SHORT);
  wire logic [15:0] min_pix   = long_mode ? 16'(PIX_LONG) : 16'(PIX_SHORT);
  wire logic [15:0] n_lines   = (lines > min_lines) ? lines : min_lines;
  wire logic [15:0] n_pix     = (pixels > min_pix) ? pixels : min_pix;
  wire logic        cnt_end   = (cnt_r == '0);
  wire logic        last_pix  = (pix_r == n_pix - 16'h1) && hph_r;
  wire logic        last_line = (line_r == n_lines - 16'h1);
  wire logic        vx_last   = (vstep_r == 3'h3);

  // frame = photodiode transfer, then lines of vertical step plus pixel burst
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:     if (start) state_nxt = ST_PD_LEAD;
      ST_PD_LEAD:  if (cnt_end) state_nxt = ST_PD_HIGH;
      ST_PD_HIGH:  if (cnt_end) state_nxt = ST_PD_TRAIL;
      ST_PD_TRAIL: if (cnt_end) state_nxt = ST_VXFER;
      ST_VXFER:    if (cnt_end && vx_last) state_nxt = ST_HDELAY;
      ST_HDELAY:   if (cnt_end) state_nxt = ST_PIXEL;
      ST_PIXEL:    if (cnt_end && last_pix) state_nxt = last_line ? ST_IDLE : ST_VXFER;
      default:     state_nxt = ST_IDLE;
    endcase
  end

  wire logic st_chg = (state_nxt != state_r);
  wire logic [CW-1:0] load_val =
      (state_nxt == ST_PD_HIGH) ? w_pd  :
      (state_nxt == ST_VXFER)   ? w_vx  :
      (state_nxt == ST_HDELAY)  ? w_hs  :
      (state_nxt == ST_PIXEL)   ? CW'(CYC_HE) : w_ped;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      line_r  <= '0;
      pix_r   <= '0;
      vstep_r <= '0;
      hph_r   <= 1'b0;
      mode_r  <= MODE_QUAD;
      cdoff_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r  <= (state_r == ST_PIXEL) && (state_nxt == ST_IDLE);
      if (state_r == ST_IDLE && start) begin
        mode_r  <= mode;
        cdoff_r <= cd_off;
        line_r  <= '0;
      end
      if (st_chg || (cnt_end && state_r != ST_IDLE)) cnt_r <= load_val - CW'(1);
      else if (!cnt_end) cnt_r <= cnt_r - CW'(1);
      if (state_r == ST_VXFER && cnt_end) vstep_r <= vstep_r + 3'h1;
      if (state_r != ST_VXFER) vstep_r <= '0;
      if (state_r == ST_PIXEL && cnt_end) begin
        hph_r <= ~hph_r;
        if (hph_r) pix_r <= pix_r + 16'h1;
      end
      if (state_r != ST_PIXEL) begin
        hph_r <= 1'b0;
        pix_r <= '0;
      end
      if (state_r == ST_PIXEL && state_nxt == ST_VXFER) line_r <= line_r + 16'h1;
    end
  end

  // cycles spent in the photodiode transfer, saturating; only the checks read it
  always_ff @(posedge clk) begin
    if (reset || state_r != ST_PD_HIGH) pd_len_r <= '0;
    else if (pd_len_r != 8'hff) pd_len_r <= pd_len_r + 8'h1;
  end

  // ---------------------------------------------------------------
  // pattern generation
  // ---------------------------------------------------------------
  // vertical steps: rising phase switches in the same step the falling one does,
  // so each rise coincides with a fall
  logic [3:0] vpat;
  always_comb begin
    case (vstep_r)
      3'h0:    vpat = 4'b1001;
      3'h1:    vpat = 4'b1100;
      3'h2:    vpat = 4'b0110;
      3'h3:    vpat = 4'b0011;
      default: vpat = 4'b1001;
    endcase
  end
  wire logic in_pd  = (state_r == ST_PD_LEAD) || (state_r == ST_PD_HIGH) ||
                      (state_r == ST_PD_TRAIL);
  // in the pedestals phase one stays mid; the high level only in between;
  // phase four rises in the same step as phase one leaves high
  wire logic [3:0] pat_b = in_pd ? {(state_r == ST_PD_TRAIL), 2'b00, 1'b1} :
                           (state_r == ST_VXFER) ? vpat : 4'b1001;
  // top side in dual a/b and single swaps phases two and four
  wire logic [3:0] pat_t_ab = {pat_b[1], pat_b[2], pat_b[3], pat_b[0]};
  wire logic top_same = (mode_r == MODE_QUAD) || (mode_r == MODE_DUAL_AC);

  // horizontal patterns five and six; seven is a reset pulse per pixel
  wire logic p5 = (state_r == ST_PIXEL) ? ~hph_r : 1'b1;
  wire logic p6 = ~p5;
  wire logic p7 = (state_r == ST_PIXEL) && ~hph_r && (cnt_r != '0);
  wire logic cd_hold = cdoff_r && (mode_r != MODE_QUAD);

  function automatic horiz_pins_t mk_h(input logic a1, input logic a2, input logic r,
                                        input logic off);
    horiz_pins_t h;
    h.h1s  = off | a1;
    h.h1b  = off | a1;
    h.h2s  = off | a2;
    h.h2b  = off | a2;
    h.horiz_last_phase_two = off | a2;   // last phase follows storage phase two
    h.rst  = off | r;
    return h;
  endfunction : mk_h

  wire logic swap_b = (mode_r == MODE_DUAL_AC) || (mode_r == MODE_SINGLE);
  wire logic d_cross = (mode_r == MODE_DUAL_AC);
  horiz_pins_t hb_w, hd_w;
  always_comb begin
    hb_w = mk_h(p5, p6, p7, 1'b0);
    if (swap_b) begin
      hb_w.h1b = p6;
      hb_w.h2b = p5;
    end
    // c/d share a/b timing so any slower clock would be a whole multiple
    hd_w = mk_h(p5, p6, p7, cd_hold && !d_cross);
    if (d_cross) begin
      hd_w.h1b = p6;
      hd_w.h2b = p5;
    end
  end
  wire logic rb_off = cd_hold && swap_b;

  always_ff @(posedge clk) begin
    if (reset) begin
      vert  <= '0;
      hor_a <= '0;
      hor_b <= '0;
      hor_c <= '0;
      hor_d <= '0;
    end else begin
      vert.bot         <= pat_b;
      vert.bot_p1_high <= (state_r == ST_PD_HIGH);
      vert.top         <= top_same ? pat_b : pat_t_ab;
      vert.top_p1_high <= (state_r == ST_PD_HIGH);
      hor_a <= mk_h(p5, p6, p7, 1'b0);
      hor_b <= hb_w;
      hor_b.rst <= rb_off | p7;
      hor_c <= mk_h(p5, p6, p7, cd_hold && (mode_r != MODE_DUAL_AC));
      hor_d <= hd_w;
      hor_d.rst <= (cd_hold || cdoff_r && mode_r == MODE_DUAL_AC) | p7;
    end
  end

  assign busy       = (state_r != ST_IDLE);
  assign frame_done = done_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_LINE_COUNT: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_PIXEL && state_nxt == ST_IDLE) |-> (line_r + 16'h1 >= min_lines))
    else $error("frame ended short of minimum lines");
  AST_PIX_COUNT: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_PIXEL && state_nxt != ST_PIXEL) |-> (pix_r + 16'h1 >= min_pix))
    else $error("line ended short of minimum pixels");
  AST_HSL_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    hor_a.horiz_last_phase_two == hor_a.h2s)
    else $error("last phase two differs from storage phase two");
  AST_H_COMPL: assert property (@(posedge clk) disable iff (reset)
    busy ##1 1'b1 |-> hor_a.h1s != hor_a.h2s)
    else $error("horizontal phases not complementary");
  AST_TOP_MAP: assert property (@(posedge clk) disable iff (reset)
    vert.top == ($past(top_same) ? vert.bot
                 : {vert.bot[1], vert.bot[2], vert.bot[3], vert.bot[0]}))
    else $error("top phases do not follow the mode mapping");
  AST_PD_WIDTH: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_PD_HIGH && state_nxt != ST_PD_HIGH) |-> (pd_len_r >= 8'(CYC_PD - 1)))
    else $error("photodiode transfer shorter than minimum");
  AST_CD_OFF: assert property (@(posedge clk) disable iff (reset)
    (cd_hold && mode_r == MODE_DUAL_AB) |=> (hor_c.h1s && hor_c.h2s && hor_c.rst))
    else $error("unused c register not held off");
  AST_V_ALIGN: assert property (@(posedge clk) disable iff (reset)
    ($changed(vert.bot) && state_r == ST_VXFER) |-> ($countones(vert.bot) == 2))
    else $error("vertical rise not aligned with fall");
endmodule : ccd_readout_pattern_sequencer

// file: hdl/ccd_seq_pkg.sv
// package: timing constants, modes and pin carrier types for the ccd clock sequencer
package ccd_seq_pkg;
  localparam int CLK_MHZ        = 50;
  // minimum interval times in nanoseconds
  localparam int T_PD_NS        = 1000;
  localparam int T_3P_NS        = 4000;
  localparam int T_3D_NS        = 4000;
  localparam int T_D_NS         = 1000;
  localparam int T_V_NS         = 1000;
  localparam int T_HS_NS        = 200;
  localparam int T_HE_NS        = 25;
  localparam int T_R_PS         = 2500; // reset pulse, picoseconds; under one cycle
  // least times round up to whole cycles
  localparam int CYC_PD         = (T_PD_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_3P         = (T_3P_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_3D         = (T_3D_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_D          = (T_D_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_V          = (T_V_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_HS         = (T_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_HE         = (T_HE_NS * CLK_MHZ + 999) / 1000;
  localparam int LINES_SHORT    = 572;
  localparam int LINES_LONG     = 1144;
  localparam int PIX_SHORT      = 1013;
  localparam int PIX_LONG       = 2026;

  typedef enum logic [1:0] {
    MODE_QUAD, MODE_DUAL_AB, MODE_DUAL_AC, MODE_SINGLE
  } readout_mode_t;

  // one horizontal output register group
  typedef struct packed {
    logic h1s;
    logic h1b;
    logic h2s;
    logic h2b;
    logic horiz_last_phase_two;
    logic rst;
  } horiz_pins_t;

  // vertical phases: bits [3:0] = phases four..one; phase one has a third level
  typedef struct packed {
    logic [3:0] top;
    logic [3:0] bot;
    logic       top_p1_high;
    logic       bot_p1_high;
  } vert_pins_t;

  function automatic int cyc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : cyc_max
endpackage : ccd_seq_pkg
